/* File: rtl/dtc_pkg.sv */
// package: register map, field positions, timing and state types of the tx serdes and correlator block
`default_nettype none
package dtc_pkg;
    // register offsets on the serial register port
    localparam logic [5:0] ADDR_CTRL      = 6'h03;
    localparam logic [5:0] ADDR_TX_IRQ_EN = 6'h0D;
    localparam logic [5:0] ADDR_TX_STAT   = 6'h0E;
    localparam logic [5:0] ADDR_TX_DATA   = 6'h0F;
    localparam logic [5:0] ADDR_TX_VALID  = 6'h10;
    localparam logic [5:0] ADDR_CODE_LO   = 6'h11;
    localparam logic [5:0] ADDR_CODE_HI   = 6'h18;
    localparam logic [5:0] ADDR_THR_ZERO  = 6'h19;
    localparam logic [5:0] ADDR_THR_ONE   = 6'h1A;
    localparam logic [5:0] ADDR_WAKE_EN   = 6'h1C;
    localparam logic [5:0] ADDR_WAKE_STAT = 6'h1D;

    // field positions
    localparam int CTRL_RX_EN_BIT = 7;
    localparam int CTRL_TX_EN_BIT = 6;
    localparam int ST_UNDERFLOW   = 3;
    localparam int ST_OVERFLOW    = 2;
    localparam int ST_DONE        = 1;
    localparam int ST_EMPTY       = 0;
    localparam int HDR_WRITE_BIT  = 7;
    localparam int HDR_INC_BIT    = 6;

    // values after reset
    localparam logic [63:0] CODE_RST      = 64'h1E8B_6A3D_E0E9_B222;
    localparam logic [6:0]  THR_ZERO_RST  = 7'h08;
    localparam logic [6:0]  THR_ONE_RST   = 7'h38;
    localparam logic        WAKE_STAT_RST = 1'b1;
    localparam logic        EMPTY_RST     = 1'b1;

    // timing: chip period is a whole number of clocks, ready delay rounds up
    localparam int CLK_PERIOD_PS     = 8000;
    localparam int CHIP_TIME_NS      = 1000;
    localparam int CHIP_CYCLES       = (CHIP_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int WAKE_READY_US     = 10;
    localparam int WAKE_READY_CYCLES = (WAKE_READY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        CM_FULL64 = 2'b00,
        CM_LOW32  = 2'b01,
        CM_HIGH32 = 2'b10,
        CM_DUAL32 = 2'b11
    } dtc_chip_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } dtc_tx_state_t;

    typedef enum logic [1:0] {
        SPI_HDR  = 2'b01,
        SPI_DATA = 2'b10
    } dtc_spi_state_t;

    typedef struct packed {
        logic           sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, ss_s1, ss_s2;
        logic           pd_s1, pd_s2, pd_s3, rxc_s1, rxc_s2;
        dtc_spi_state_t spi_st;
        logic [2:0]     spi_bits;
        logic [7:0]     spi_in, spi_out;
        logic [5:0]     spi_addr;
        logic           spi_wr, spi_inc, miso, miso_oe, irq;
        logic           ctrl_rx, ctrl_tx;
        logic [3:0]     irq_en;
        logic           st_under, st_over, st_done, st_empty;
        logic [7:0]     hold_data, valid_reg;
        logic           hold_full;
        dtc_tx_state_t  tx_st;
        logic [7:0]     sh_data, sh_mask, tx_tmr, rx_tmr;
        logic [5:0]     tx_idx, rx_idx;
        logic           sent_any, tx_half, tx_chip, tx_active;
        logic [63:0]    code;
        logic [6:0]     thr_zero, thr_one, rx_match;
        logic           wake_en, wake_st, wake_wait;
        logic [11:0]    wake_cnt;
        logic           rx_half, rx_bit, rx_valid, rx_strobe;
    } dtc_state_t;
endpackage : dtc_pkg
`default_nettype wire

/* File: rtl/dtc_serdes.sv */
// transmit serdes, spreading code, correlator thresholds and wakeup logic behind a serial register port
//
// Behaviour
// - underflow flag bit 3 sets when next data bit is needed but none waits
// - underflow only after at least one bit of the transmission went out
// - overflow flag bit 2 sets on a data write while previous byte unsent
// - done flag bit 1 sets when a byte ends with nothing waiting, after a bit
// - reading transmit status clears underflow, overflow and done
// - writing transmit data clears the empty flag bit 0
// - empty sets again when the byte moves into the shifter
// - status flags set and readable regardless of interrupt enables
// - transmit status reads zero unless transmit mode is enabled
// - data bytes go out least significant bit first
// - valid mask bit 1 sends data, 0 sends preamble for that bit time
// - sending stops when no valid-marked bits remain in the shifter
// - eight-byte code register is the spreading sequence, with its reset value
// - one 64-chip code, or two 32-chip halves used singly or alternately
// - code chips leave in rising bit order: 0 to 63 in full mode, 0 to 31 or 32 to 63 per half
// - match count at or below low threshold decodes logic 0
// - match count at or above high threshold decodes logic 1
// - correlator counts chip matches; perfect 1 gives full chip count
// - wakeup interrupt only when wake enable bit 0 is set
// - wakeup event once power-down pin released and device ready
// - wake status bit 0 shows pending wakeup, cleared by reading it
// - each transmit status flag gated to interrupt by its enable bit
`default_nettype none
module dtc_serdes #(
    parameter int CHIP_CYC = dtc_pkg::CHIP_CYCLES,
    parameter int WAKE_CYC = dtc_pkg::WAKE_READY_CYCLES
) (
    // clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    // serial register port, mode 0, msb first
    input  wire logic       SPI_SCK,
    input  wire logic       SPI_MOSI,
    input  wire logic       SPI_SS_N,
    output logic            SPI_MISO,
    output logic            SPI_MISO_OE,
    // device pins
    input  wire logic       POWER_DOWN_PIN_N,
    input  wire logic [1:0] CHIP_MODE,
    output logic            IRQ,
    // chip streams toward and from the radio
    output logic            TX_CHIP,
    output logic            TX_ACTIVE,
    input  wire logic       RX_CHIP,
    output logic            RX_BIT,
    output logic            RX_BIT_VALID,
    output logic            RX_BIT_STROBE
);
    if (CHIP_CYC < 2 || CHIP_CYC > 256) begin : g_bad_chip
        $error("CHIP_CYC must lie in 2..256");
    end
    if (WAKE_CYC < 1 || WAKE_CYC > 4095) begin : g_bad_wake
        $error("WAKE_CYC must lie in 1..4095");
    end

    localparam logic [7:0]  CHIP_LAST = 8'(CHIP_CYC - 1);
    localparam logic [11:0] WAKE_LAST = 12'(WAKE_CYC - 1);

    // chip of the active code slice for chip index i of the current bit
    function automatic logic code_chip(input logic [63:0] c, input logic [1:0] m,
                                       input logic h, input logic [5:0] i);
        logic [5:0] p;
        p = i;
        if (m == dtc_pkg::CM_HIGH32 || (m == dtc_pkg::CM_DUAL32 && h)) begin
            p = {1'b1, i[4:0]};
        end else if (m != dtc_pkg::CM_FULL64) begin
            p = {1'b0, i[4:0]};
        end
        return c[p];
    endfunction : code_chip

    function automatic logic last_chip(input logic [1:0] m, input logic [5:0] i);
        return (m == dtc_pkg::CM_FULL64) ? (i == 6'h3F) : (i[4:0] == 5'h1F);
    endfunction : last_chip

    dtc_pkg::dtc_state_t q, d;

    always_comb begin
        logic       sck_rise, sck_fall, byte_done, rd_load, wr_commit, pd_rise;
        logic       tx_tick, bit_end, byte_end, rx_tick, chip;
        logic [7:0] new_in, rd_val, nmask;
        logic [5:0] rd_addr;
        logic [6:0] cnt;
        logic [3:0] tx_view;
        sck_rise  = 1'b0;
        sck_fall  = 1'b0;
        byte_done = 1'b0;
        rd_load   = 1'b0;
        wr_commit = 1'b0;
        pd_rise   = 1'b0;
        tx_tick   = 1'b0;
        bit_end   = 1'b0;
        byte_end  = 1'b0;
        rx_tick   = 1'b0;
        chip      = 1'b0;
        new_in    = 8'h00;
        rd_val    = 8'h00;
        nmask     = 8'h00;
        rd_addr   = 6'h00;
        cnt       = 7'h00;
        tx_view   = 4'h0;
        d = q;

        // pin synchronisers; logic reads the second stage, and the third stage of sck and power-down for edge detection
        d.sck_s1  = SPI_SCK;
        d.sck_s2  = q.sck_s1;
        d.sck_s3  = q.sck_s2;
        d.mosi_s1 = SPI_MOSI;
        d.mosi_s2 = q.mosi_s1;
        d.ss_s1   = SPI_SS_N;
        d.ss_s2   = q.ss_s1;
        d.pd_s1   = POWER_DOWN_PIN_N;
        d.pd_s2   = q.pd_s1;
        d.pd_s3   = q.pd_s2;
        d.rxc_s1  = RX_CHIP;
        d.rxc_s2  = q.rxc_s1;

        // serial port framing
        sck_rise = q.sck_s2 & ~q.sck_s3 & ~q.ss_s2;
        sck_fall = ~q.sck_s2 & q.sck_s3 & ~q.ss_s2;
        new_in   = {q.spi_in[6:0], q.mosi_s2};
        if (q.ss_s2) begin
            d.spi_st   = dtc_pkg::SPI_HDR;
            d.spi_bits = 3'h0;
        end else if (sck_rise) begin
            d.spi_in   = new_in;
            d.spi_bits = q.spi_bits + 3'h1;
            byte_done  = (q.spi_bits == 3'h7);
        end else if (sck_fall && q.spi_bits != 3'h0) begin
            // no shift on the eighth falling edge: the next byte is already loaded
            d.spi_out = {q.spi_out[6:0], 1'b0};
        end
        if (byte_done) begin
            if (q.spi_st == dtc_pkg::SPI_HDR) begin
                d.spi_st   = dtc_pkg::SPI_DATA;
                d.spi_wr   = new_in[dtc_pkg::HDR_WRITE_BIT];
                d.spi_inc  = new_in[dtc_pkg::HDR_INC_BIT];
                d.spi_addr = new_in[5:0];
                rd_addr    = new_in[5:0];
                rd_load    = ~new_in[dtc_pkg::HDR_WRITE_BIT];
            end else begin
                wr_commit = q.spi_wr;
                if (q.spi_inc) begin
                    d.spi_addr = q.spi_addr + 6'h01;
                end
                rd_addr = d.spi_addr;
                rd_load = ~q.spi_wr;
            end
        end

        // read data; transmit status view is masked outside transmit mode
        tx_view = q.ctrl_tx ? {q.st_under, q.st_over, q.st_done, q.st_empty} : 4'h0;
        case (rd_addr)
            dtc_pkg::ADDR_CTRL:      rd_val = {q.ctrl_rx, q.ctrl_tx, 6'h00};
            dtc_pkg::ADDR_TX_IRQ_EN: rd_val = {4'h0, q.irq_en};
            dtc_pkg::ADDR_TX_STAT:   rd_val = {4'h0, tx_view};
            dtc_pkg::ADDR_TX_DATA:   rd_val = q.hold_data;
            dtc_pkg::ADDR_TX_VALID:  rd_val = q.valid_reg;
            dtc_pkg::ADDR_THR_ZERO:  rd_val = {1'b0, q.thr_zero};
            dtc_pkg::ADDR_THR_ONE:   rd_val = {1'b0, q.thr_one};
            dtc_pkg::ADDR_WAKE_EN:   rd_val = {7'h00, q.wake_en};
            dtc_pkg::ADDR_WAKE_STAT: rd_val = {7'h00, q.wake_st};
            default: begin
                if (rd_addr >= dtc_pkg::ADDR_CODE_LO && rd_addr <= dtc_pkg::ADDR_CODE_HI) begin
                    rd_val = q.code[8 * (3'(rd_addr - dtc_pkg::ADDR_CODE_LO)) +: 8];
                end else begin
                    rd_val = 8'h00;
                end
            end
        endcase
        if (rd_load) begin
            d.spi_out = rd_val;
            // only the header's load clears: a prefetch may never be shifted out; a same-cycle set still wins
            if (rd_addr == dtc_pkg::ADDR_TX_STAT && q.spi_st == dtc_pkg::SPI_HDR) begin
                d.st_under = 1'b0;
                d.st_over  = 1'b0;
                d.st_done  = 1'b0;
            end
            if (rd_addr == dtc_pkg::ADDR_WAKE_STAT && q.spi_st == dtc_pkg::SPI_HDR) begin
                d.wake_st = 1'b0;
            end
        end

        // transmit serializer
        chip    = code_chip(q.code, CHIP_MODE, q.tx_half, q.tx_idx);
        tx_tick = (q.tx_tmr == CHIP_LAST);
        nmask   = {1'b0, q.sh_mask[7:1]};
        case (q.tx_st)
            dtc_pkg::TX_IDLE: begin
                d.tx_active = 1'b0;
                d.tx_chip   = 1'b0;
                d.sent_any  = 1'b0;
                if (q.ctrl_tx && q.hold_full) begin
                    d.sh_data   = q.hold_data;
                    d.sh_mask   = q.valid_reg;
                    d.hold_full = 1'b0;
                    d.st_empty  = 1'b1;
                    d.tx_st     = dtc_pkg::TX_SEND;
                    d.tx_tmr    = 8'h00;
                    d.tx_idx    = 6'h00;
                    d.tx_half   = 1'b0;
                end
            end
            dtc_pkg::TX_SEND: begin
                d.tx_active = 1'b1;
                // data bit, or the inverted code for a 0; preamble is the plain code
                d.tx_chip = q.sh_mask[0] ? (chip ^ ~q.sh_data[0]) : chip;
                d.tx_tmr  = tx_tick ? 8'h00 : q.tx_tmr + 8'h01;
                if (q.sh_mask == 8'h00) begin
                    byte_end = 1'b1;
                end else if (tx_tick) begin
                    d.tx_idx = q.tx_idx + 6'h01;
                    if (last_chip(CHIP_MODE, q.tx_idx)) begin
                        bit_end   = 1'b1;
                        d.tx_idx  = 6'h00;
                        d.tx_half = ~q.tx_half;
                        d.sh_data = {1'b0, q.sh_data[7:1]};
                        d.sh_mask = nmask;
                        d.sent_any = 1'b1;
                        byte_end  = (nmask == 8'h00);
                    end
                end
                if (!q.ctrl_tx) begin
                    d.tx_st = dtc_pkg::TX_IDLE;
                end else if (byte_end) begin
                    if (q.hold_full) begin
                        d.sh_data   = q.hold_data;
                        d.sh_mask   = q.valid_reg;
                        d.hold_full = 1'b0;
                        d.st_empty  = 1'b1;
                        d.tx_tmr    = 8'h00;
                        d.tx_idx    = 6'h00;
                    end else begin
                        d.tx_st = dtc_pkg::TX_IDLE;
                        if (q.sent_any || bit_end) begin
                            d.st_done  = 1'b1;
                            d.st_under = 1'b1;
                        end
                    end
                end
            end
            default: d.tx_st = dtc_pkg::TX_IDLE;
        endcase

        // register writes come after the shifter load so a same-cycle load is seen
        if (wr_commit) begin
            case (q.spi_addr)
                dtc_pkg::ADDR_CTRL: begin
                    d.ctrl_rx = new_in[dtc_pkg::CTRL_RX_EN_BIT];
                    d.ctrl_tx = new_in[dtc_pkg::CTRL_TX_EN_BIT];
                end
                dtc_pkg::ADDR_TX_IRQ_EN: d.irq_en = new_in[3:0];
                dtc_pkg::ADDR_TX_DATA: begin
                    d.hold_data = new_in;
                    if (d.hold_full) begin
                        d.st_over = 1'b1;
                    end
                    d.hold_full = 1'b1;
                    d.st_empty  = 1'b0;
                end
                dtc_pkg::ADDR_TX_VALID: d.valid_reg = new_in;
                dtc_pkg::ADDR_THR_ZERO: d.thr_zero  = new_in[6:0];
                dtc_pkg::ADDR_THR_ONE:  d.thr_one   = new_in[6:0];
                dtc_pkg::ADDR_WAKE_EN:  d.wake_en   = new_in[0];
                default: begin
                    if (q.spi_addr >= dtc_pkg::ADDR_CODE_LO && q.spi_addr <= dtc_pkg::ADDR_CODE_HI) begin
                        d.code[8 * (3'(q.spi_addr - dtc_pkg::ADDR_CODE_LO)) +: 8] = new_in;
                    end
                end
            endcase
        end

        // correlator: one sample per chip, aligned to receive enable
        d.rx_strobe = 1'b0;
        rx_tick = (q.rx_tmr == CHIP_LAST);
        if (!q.ctrl_rx) begin
            d.rx_tmr   = 8'h00;
            d.rx_idx   = 6'h00;
            d.rx_match = 7'h00;
            d.rx_half  = 1'b0;
        end else begin
            d.rx_tmr = rx_tick ? 8'h00 : q.rx_tmr + 8'h01;
            if (rx_tick) begin
                cnt = q.rx_match + {6'h00, q.rxc_s2 == code_chip(q.code, CHIP_MODE, q.rx_half, q.rx_idx)};
                d.rx_match = cnt;
                d.rx_idx   = q.rx_idx + 6'h01;
                if (last_chip(CHIP_MODE, q.rx_idx)) begin
                    d.rx_idx    = 6'h00;
                    d.rx_match  = 7'h00;
                    d.rx_half   = ~q.rx_half;
                    d.rx_strobe = 1'b1;
                    if (cnt <= q.thr_zero) begin
                        d.rx_bit   = 1'b0;
                        d.rx_valid = 1'b1;
                    end else if (cnt >= q.thr_one) begin
                        d.rx_bit   = 1'b1;
                        d.rx_valid = 1'b1;
                    end else begin
                        d.rx_bit   = 1'b0;
                        d.rx_valid = 1'b0;
                    end
                end
            end
        end

        // wakeup: ready delay after the power-down pin is released
        pd_rise = q.pd_s2 & ~q.pd_s3;
        if (!q.pd_s2) begin
            d.wake_wait = 1'b0;
        end else if (pd_rise) begin
            d.wake_wait = 1'b1;
            d.wake_cnt  = 12'h000;
        end else if (q.wake_wait) begin
            d.wake_cnt = q.wake_cnt + 12'h001;
            if (q.wake_cnt == WAKE_LAST) begin
                d.wake_wait = 1'b0;
                d.wake_st   = 1'b1;
            end
        end

        // serial output pins and the single interrupt output
        d.miso    = d.spi_out[7];
        d.miso_oe = ~q.ss_s2;
        d.irq     = (|(q.irq_en & tx_view)) | (q.wake_en & q.wake_st);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q          <= '0;
            q.sck_s1   <= 1'b0;
            q.ss_s1    <= 1'b1;
            q.ss_s2    <= 1'b1;
            q.spi_st   <= dtc_pkg::SPI_HDR;
            q.tx_st    <= dtc_pkg::TX_IDLE;
            q.st_empty <= dtc_pkg::EMPTY_RST;
            q.code     <= dtc_pkg::CODE_RST;
            q.thr_zero <= dtc_pkg::THR_ZERO_RST;
            q.thr_one  <= dtc_pkg::THR_ONE_RST;
            q.wake_st  <= dtc_pkg::WAKE_STAT_RST;
        end else begin
            q <= d;
        end
    end

    assign SPI_MISO      = q.miso;
    assign SPI_MISO_OE   = q.miso_oe;
    assign IRQ           = q.irq;
    assign TX_CHIP       = q.tx_chip;
    assign TX_ACTIVE     = q.tx_active;
    assign RX_BIT        = q.rx_bit;
    assign RX_BIT_VALID  = q.rx_valid;
    assign RX_BIT_STROBE = q.rx_strobe;
endmodule : dtc_serdes
`default_nettype wire

/* File: tb/dtc_radio_model.sv */
// far radio: samples each outgoing chip mid-period, sends a commanded chip level back
`default_nettype none
module dtc_radio_model #(
    parameter int CHIP_CYC = 4
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // air link
    input wire logic        tx_active,
    input wire logic        tx_chip,
    output logic            rx_chip,
    // control and capture
    input wire logic        level,
    input wire logic        clr,
    input wire logic [6:0]  cpb,
    output logic [15:0]     n_chips,
    output logic [15:0]     bits
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph;
    assign rx_chip = level;
    // first chip of each bit carries the bit value while the code bit there is 1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 0;
            n_chips <= 16'h0000;
            bits <= 16'h0000;
        end else if (clr) begin
            n_chips <= 16'h0000;
            bits <= 16'h0000;
        end else if (tx_active) begin
            ph <= (ph == CHIP_CYC - 1) ? 0 : ph + 1;
            if (ph == 1) begin
                if (n_chips % cpb == 0) bits[n_chips / cpb] <= tx_chip;
                n_chips <= n_chips + 16'h0001;
            end
        end else begin
            ph <= 0;
        end
    end
endmodule : dtc_radio_model
`default_nettype wire

/* File: tb/dtc_serdes_properties.sv */
// checker: timing relations at the ports of the tx serdes block
`default_nettype none
module dtc_serdes_properties #(
    parameter int CHIP_CYC = 4,
    parameter int WAKE_CYC = 8
) (
    // clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    // register port
    input wire logic       SPI_SCK,
    input wire logic       SPI_MOSI,
    input wire logic       SPI_SS_N,
    input wire logic       SPI_MISO,
    input wire logic       SPI_MISO_OE,
    // device pins
    input wire logic       POWER_DOWN_PIN_N,
    input wire logic [1:0] CHIP_MODE,
    input wire logic       IRQ,
    // chip streams
    input wire logic       TX_CHIP,
    input wire logic       TX_ACTIVE,
    input wire logic       RX_CHIP,
    input wire logic       RX_BIT,
    input wire logic       RX_BIT_VALID,
    input wire logic       RX_BIT_STROBE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        chip_q, act_q;
    logic [15:0] run_q, frame_q;
    logic [4:0]  up_q;
    // run_q holds the length of the chip level run that ends at a change
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chip_q <= 1'b0;
            act_q <= 1'b0;
            run_q <= 16'h0000;
            frame_q <= 16'h0000;
            up_q <= 5'h00;
        end else begin
            chip_q <= TX_CHIP;
            act_q <= TX_ACTIVE;
            run_q <= (TX_CHIP != chip_q || (TX_ACTIVE && !act_q)) ? 16'h0001 : run_q + 16'h0001;
            frame_q <= TX_ACTIVE ? frame_q + 16'h0001 : 16'h0000;
            up_q <= (up_q == 5'h1F) ? up_q : up_q + 5'h01;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_selected;
        !SPI_SS_N [*5];
    endsequence
    sequence s_released;
        SPI_SS_N [*5];
    endsequence
    a_oe_select: assert property (s_selected |-> SPI_MISO_OE) else $error("miso not enabled while selected");
    a_oe_release: assert property (s_released |-> !SPI_MISO_OE) else $error("miso driven while idle");
    a_chip_period: assert property (TX_ACTIVE && act_q && TX_CHIP != chip_q |-> run_q % CHIP_CYC == 0)
        else $error("chip changed off the chip grid");
    a_frame_length: assert property (!TX_ACTIVE && act_q |->
        frame_q % ((CHIP_MODE == 2'd0 ? 64 : 32) * CHIP_CYC) == 0)
        else $error("frame not a whole number of bits");
    a_frame_min: assert property ($rose(TX_ACTIVE) |-> TX_ACTIVE [*8]) else $error("frame too short");
    a_strobe_pulse: assert property (RX_BIT_STROBE |=> !RX_BIT_STROBE [*8]) else $error("strobe too close");
    a_bit_hold: assert property (RX_BIT_STROBE |=> $stable(RX_BIT) [*4]) else $error("rx bit not held");
    a_irq_quiet: assert property (up_q < 5'h14 |-> !IRQ) else $error("irq right after reset");
endmodule : dtc_serdes_properties
bind dtc_serdes dtc_serdes_properties #(.CHIP_CYC(CHIP_CYC), .WAKE_CYC(WAKE_CYC)) dtc_serdes_properties_i (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_SS_N(SPI_SS_N),
    .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N),
    .CHIP_MODE(CHIP_MODE), .IRQ(IRQ), .TX_CHIP(TX_CHIP), .TX_ACTIVE(TX_ACTIVE), .RX_CHIP(RX_CHIP),
    .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT_STROBE(RX_BIT_STROBE));
`default_nettype wire

/* File: tb/dtc_serdes_tb.sv */
// testbench: register port tasks and directed tests of the tx serdes block
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dtc_serdes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, sck, mosi, ss_n, pd_n, lvl, clr, miso, irq, txc, txa, rxc, rxb, rxv, rxs;
    logic [1:0] mode;
    logic [15:0] n_chips, bits;
    logic [7:0] r8;
    logic [63:0] r64;
    int fails, samples_checked;
    dtc_serdes #(.CHIP_CYC(4), .WAKE_CYC(8)) dtc_serdes_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .SPI_SCK(sck),
        .SPI_MOSI(mosi), .SPI_SS_N(ss_n), .SPI_MISO(miso), .SPI_MISO_OE(), .POWER_DOWN_PIN_N(pd_n),
        .CHIP_MODE(mode), .IRQ(irq), .TX_CHIP(txc), .TX_ACTIVE(txa), .RX_CHIP(rxc), .RX_BIT(rxb),
        .RX_BIT_VALID(rxv), .RX_BIT_STROBE(rxs));
    dtc_radio_model #(.CHIP_CYC(4)) dtc_radio_model_i (.clk(sys_clk), .rst_n(rst_n), .tx_active(txa),
        .tx_chip(txc), .rx_chip(rxc), .level(lvl), .clr(clr), .cpb(mode == 2'd0 ? 7'd64 : 7'd32),
        .n_chips(n_chips), .bits(bits));
    task automatic spi(input logic [7:0] hdr, input int n, input logic [63:0] wv, output logic [63:0] rv);
        logic [7:0] b;
        rv = '0;
        ss_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int k = 0; k <= n; k++) begin
            b = (k == 0) ? hdr : wv[8*(k-1) +: 8];
            for (int i = 7; i >= 0; i--) begin
                mosi = b[i];
                repeat (6) @(negedge sys_clk);
                if (k > 0) rv[8*(k-1)+i] = miso;
                sck = 1'b1;
                repeat (6) @(negedge sys_clk);
                sck = 1'b0;
            end
        end
        repeat (6) @(negedge sys_clk);
        ss_n = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask : spi
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [63:0] rv;
        spi({2'b10, a}, 1, {56'h0, d}, rv);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        logic [63:0] rv;
        spi({2'b00, a}, 1, 64'h0, rv);
        d = rv[7:0];
    endtask : rd
    task automatic tx_wait;
        for (int t = 0; t < 20000 && txa === 1'b1; t++) @(negedge sys_clk);
        `CHK(txa, 1'b0)
    endtask : tx_wait
    task automatic strobes(input int n);
        for (int k = 0; k < n; k++) begin
            for (int t = 0; t < 2000 && rxs !== 1'b1; t++) @(negedge sys_clk);
            `CHK(rxs, 1'b1)
            @(negedge sys_clk);
        end
    endtask : strobes
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        report_and_stop;
    end
    initial begin
        logic [7:0] m [5] = '{8'h0F, 8'h05, 8'h03, 8'h03, 8'hFF};
        logic [7:0] d [5] = '{8'hA5, 8'h00, 8'h01, 8'h03, 8'h00};
        logic [15:0] e [5] = '{16'h0005, 16'h0002, 16'h0002, 16'h0001, 16'h0000};
        int nb [5] = '{4, 3, 2, 2, 8};
        rst_n = 1'b0; sck = 1'b0; mosi = 1'b0; ss_n = 1'b1; pd_n = 1'b1; lvl = 1'b0; clr = 1'b0; mode = 2'd0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(dtc_pkg::ADDR_THR_ZERO, r8); `CHK(r8, 8'h08)
        rd(dtc_pkg::ADDR_THR_ONE, r8); `CHK(r8, 8'h38)
        rd(dtc_pkg::ADDR_WAKE_STAT, r8); `CHK(r8, 8'h01)
        rd(dtc_pkg::ADDR_WAKE_STAT, r8); `CHK(r8, 8'h00)
        rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h00)
        rd(6'h3F, r8); `CHK(r8, 8'h00)
        spi({2'b01, dtc_pkg::ADDR_CODE_LO}, 8, 64'h0, r64); `CHK(r64, dtc_pkg::CODE_RST)
        spi({2'b11, dtc_pkg::ADDR_CODE_LO}, 8, 64'h0000_0000_FFFF_FFFF, r64);
        spi({2'b01, dtc_pkg::ADDR_CODE_LO}, 8, 64'h0, r64); `CHK(r64, 64'h0000_0000_FFFF_FFFF)
        $display("test registers done");
        wr(dtc_pkg::ADDR_CTRL, 8'h40);
        rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h01)
        // one frame per chip mode, then back-to-back bytes in dual mode
        for (int k = 0; k < 4; k++) begin
            mode = 2'(k);
            clr = 1'b1;
            @(negedge sys_clk);
            clr = 1'b0;
            wr(dtc_pkg::ADDR_TX_VALID, m[k]);
            wr(dtc_pkg::ADDR_TX_DATA, d[k]);
            tx_wait;
            `CHK(n_chips, 16'(nb[k] * (k == 0 ? 64 : 32)))
            `CHK(bits, e[k])
            rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h0B)
            rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h01)
        end
        clr = 1'b1;
        @(negedge sys_clk);
        clr = 1'b0;
        wr(dtc_pkg::ADDR_TX_VALID, m[4]);
        wr(dtc_pkg::ADDR_TX_DATA, 8'h11);
        wr(dtc_pkg::ADDR_TX_DATA, 8'h22);
        wr(dtc_pkg::ADDR_TX_DATA, 8'h33);
        rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h04)
        tx_wait;
        `CHK(n_chips, 16'(2 * nb[4] * 32))
        `CHK(bits, 16'h99BB)
        rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h0B)
        wr(dtc_pkg::ADDR_TX_IRQ_EN, 8'h01);
        repeat (4) @(negedge sys_clk);
        `CHK(irq, 1'b1)
        wr(dtc_pkg::ADDR_TX_IRQ_EN, 8'h02);
        `CHK(irq, 1'b0)
        wr(dtc_pkg::ADDR_TX_IRQ_EN, 8'h00);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd(dtc_pkg::ADDR_TX_STAT, r8); `CHK(r8, 8'h00)
        $display("test transmit done");
        for (int k = 0; k < 2; k++) begin
            pd_n = 1'b0;
            repeat (4) @(negedge sys_clk);
            pd_n = 1'b1;
            repeat (30) @(negedge sys_clk);
            `CHK(irq, 1'(k))
            rd(dtc_pkg::ADDR_WAKE_STAT, r8); `CHK(r8, 8'h01)
            `CHK(irq, 1'b0)
            wr(dtc_pkg::ADDR_WAKE_EN, 8'h01);
        end
        $display("test wakeup done");
        mode = 2'd1;
        wr(dtc_pkg::ADDR_CTRL, 8'h80);
        strobes(2);
        `CHK({rxb, rxv}, 2'b01)
        lvl = 1'b1;
        strobes(2);
        `CHK(rxv, 1'b0)
        wr(dtc_pkg::ADDR_THR_ONE, 8'h20);
        strobes(2);
        `CHK({rxb, rxv}, 2'b11)
        $display("test correlator done");
        report_and_stop;
    end
endmodule : dtc_serdes_tb
`default_nettype wire
